// File: common/dsp_cmd_pkg.sv
/*
 Constants for the host command decoder: register offsets, opcodes,
 reset values and clock rates.
 Assumes a 25 MHz system clock and 32-bit AXI4-Lite register access.
*/
package dsp_cmd_pkg;
   // ----------------------------------------
   // register offsets (byte addresses)
   // ----------------------------------------
   localparam logic [7:0] CMD_OFS = 8'h00;
   localparam logic [7:0] STATUS_OFS = 8'h04;
   localparam logic [7:0] RDATA_OFS = 8'h08;
   localparam logic [7:0] CONFIG_OFS = 8'h0c;
   localparam logic [7:0] TIMER_OFS = 8'h10;
   localparam logic [7:0] DAC_OFS = 8'h14;
   localparam logic [7:0] BLOCK_OFS = 8'h18;
   // ----------------------------------------
   // field positions and reset values
   // ----------------------------------------
   localparam int STAT_BUSY = 0;
   localparam int STAT_AVAIL = 1;
   localparam int STAT_IRQ = 2;
   localparam int STAT_RATE_ERR = 3;
   localparam int STAT_IDLE = 6;
   localparam int CFG_SRST = 0;
   localparam int CFG_STEREO = 1;
   localparam int CFG_GAIN_LSB = 8;
   localparam logic [3:0] GAIN_RESET = 4'h8;
   localparam logic [7:0] TIMER_X_RESET = 8'h83; // 1 MHz / 125 = 8 kHz
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_DECERR = 2'h3;
   // ----------------------------------------
   // opcodes
   // ----------------------------------------
   localparam logic [7:0] OP_DAC8 = 8'h10;
   localparam logic [7:0] OP_DAC16 = 8'h11;
   localparam logic [7:0] OP_PLAY8 = 8'h14;
   localparam logic [7:0] OP_PLAY16 = 8'h15;
   localparam logic [7:0] OP_PLAY8_AUTO = 8'h1c;
   localparam logic [7:0] OP_PLAY16_AUTO = 8'h1d;
   localparam logic [7:0] OP_ADC8 = 8'h20;
   localparam logic [7:0] OP_ADC16 = 8'h21;
   localparam logic [7:0] OP_REC8 = 8'h24;
   localparam logic [7:0] OP_REC16 = 8'h25;
   localparam logic [7:0] OP_REC8_AUTO = 8'h2c;
   localparam logic [7:0] OP_REC16_AUTO = 8'h2d;
   localparam logic [7:0] OP_MIDI_IN = 8'h30;
   localparam logic [7:0] OP_MIDI_IN_IRQ = 8'h31;
   localparam logic [7:0] OP_MIDI_UART = 8'h34;
   localparam logic [7:0] OP_MIDI_UART_IRQ = 8'h35;
   localparam logic [7:0] OP_MIDI_OUT = 8'h38;
   localparam logic [7:0] OP_TIMER = 8'h40;
   localparam logic [7:0] OP_TIMER_ALT = 8'h41;
   localparam logic [7:0] OP_FILTER = 8'h42;
   localparam logic [7:0] OP_BLOCK = 8'h48;
   localparam logic [7:0] OP_HS_REC_AUTO = 8'h98;
   localparam logic [7:0] OP_HS_REC = 8'h99;
   // ----------------------------------------
   // clock rates and rate ceilings
   // ----------------------------------------
   localparam int unsigned CLK_HZ = 25_000_000;
   localparam int unsigned TIMER_HZ = 1_000_000;
   localparam int unsigned TIMER_ALT_HZ = 1_500_000;
   localparam int unsigned FILTER_HZ = 7_160_000;
   localparam int unsigned RATE_HI_KHZ = 44;
   localparam int unsigned RATE_LO_KHZ = 22;
   typedef enum {DEC_IDLE, DEC_PARAM1, DEC_PARAM2} dec_state_type;
   typedef enum logic [1:0] {MIDI_OFF, MIDI_INPUT, MIDI_UART} midi_mode_type;
endpackage

// File: design/dsp_cmd_decoder.sv
/*
 Host command decoder for the compatibility-mode sound engine, with its
 AXI4-Lite register slave, sample timer and filter clock generators.
 Assumes a 25 MHz aclk, a synchronous active-low reset, and that the
 host polls the busy bit before each byte written to the command port.
*/
// Decided for this implementation: register access over AXI4-Lite and the placing of the registers.
`timescale 1ns/10ps
`default_nettype none
module dsp_cmd_decoder (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic awvalid,
   output logic awready,
   input wire logic [7:0] awaddr,
   input wire logic wvalid,
   output logic wready,
   input wire logic [31:0] wdata,
   input wire logic [3:0] wstrb,
   output logic bvalid,
   input wire logic bready,
   output logic [1:0] bresp,
   input wire logic arvalid,
   output logic arready,
   input wire logic [7:0] araddr,
   output logic rvalid,
   input wire logic rready,
   output logic [31:0] rdata,
   output logic [1:0] rresp,
   output logic [15:0] dac_data,
   output logic dac_wide,
   output logic dac_strobe,
   input wire logic [15:0] adc_sample,
   output logic agc_enable,
   output logic [3:0] adc_gain,
   output logic dma_start,
   output logic dma_record,
   output logic dma_wide,
   output logic dma_auto,
   output logic dma_stereo,
   output logic dma_high_speed,
   output logic [15:0] dma_count,
   output logic sample_tick,
   output logic filter_tick,
   input wire logic midi_rx_valid,
   input wire logic [7:0] midi_rx_data,
   output logic midi_tx_valid,
   input wire logic midi_tx_ready,
   output logic [7:0] midi_tx_data,
   output logic midi_irq
);
   import dsp_cmd_pkg::*;

   // ----------------------------------------
   // helpers
   // ----------------------------------------
   // parameter bytes each opcode gathers; unknown opcodes take none
   function automatic logic [1:0] param_count(input logic [7:0] op);
      case (op)
         OP_DAC8, OP_MIDI_OUT, OP_TIMER, OP_TIMER_ALT, OP_FILTER: param_count = 2'h1;
         OP_DAC16, OP_PLAY8, OP_PLAY16, OP_REC8, OP_REC16, OP_BLOCK: param_count = 2'h2;
         default: param_count = 2'h0;
      endcase
   endfunction

   // true when base/(256-x) stays below the next whole kHz above the ceiling
   function automatic logic rate_ok(input logic [7:0] x, input logic alt,
                                    input int unsigned limit_khz);
      int unsigned base;
      int unsigned div;
      base = alt ? TIMER_ALT_HZ : TIMER_HZ;
      div = 256 - int'(x);
      rate_ok = base < (limit_khz + 1) * 1000 * div;
   endfunction

   // ----------------------------------------
   // register bus state
   // ----------------------------------------
   logic [7:0] aw_addr;
   logic [31:0] w_data;
   logic [3:0] w_strb;
   logic wr_fire;
   logic rd_take;
   logic cmd_write;
   logic rdata_read;
   logic soft_rst;
   logic stereo;
   logic rate_err;
   logic [7:0] timer_x;
   logic [7:0] filter_x;
   logic timer_alt;
   logic [15:0] block_size;
   logic [7:0] read_byte;
   logic [7:0] hi_byte;
   logic hi_pending;
   logic data_avail;
   logic irq_en;
   midi_mode_type midi_mode;
   dec_state_type dec_state;
   logic [7:0] opcode;
   logic [7:0] param_lo;

   // write executes once both address and data are held and no answer is out
   assign wr_fire = !awready && !wready && !bvalid;
   assign rd_take = arvalid && arready;
   assign cmd_write = wr_fire && aw_addr == CMD_OFS && w_strb[0];
   assign rdata_read = rd_take && araddr == RDATA_OFS;

   // ----------------------------------------
   // AXI4-Lite write channels
   // ----------------------------------------
   // address and data are taken in either order, one write at a time
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         awready <= 1'b1;
         wready <= 1'b1;
         bvalid <= 1'b0;
         bresp <= RESP_OKAY;
         aw_addr <= 8'h00;
         w_data <= 32'h0000_0000;
         w_strb <= 4'h0;
      end else begin
         if (awvalid && awready) begin
            awready <= 1'b0;
            aw_addr <= awaddr;
         end
         if (wvalid && wready) begin
            wready <= 1'b0;
            w_data <= wdata;
            w_strb <= wstrb;
         end
         if (wr_fire) begin
            bvalid <= 1'b1;
            bresp <= (aw_addr <= BLOCK_OFS && aw_addr[1:0] == 2'h0) ? RESP_OKAY
                                                                   : RESP_DECERR;
         end
         if (bvalid && bready) begin
            bvalid <= 1'b0;
            awready <= 1'b1;
            wready <= 1'b1;
         end
      end
   end

   // ----------------------------------------
   // AXI4-Lite read channels
   // ----------------------------------------
   // data is captured at the address edge, so read side effects happen then
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         arready <= 1'b1;
         rvalid <= 1'b0;
         rdata <= 32'h0000_0000;
         rresp <= RESP_OKAY;
      end else begin
         if (rd_take) begin
            arready <= 1'b0;
            rvalid <= 1'b1;
            rresp <= RESP_OKAY;
            case (araddr)
               CMD_OFS: rdata <= 32'h0000_0000;
               STATUS_OFS: rdata <= {25'h0, dec_state == DEC_IDLE, midi_mode,
                                     rate_err, midi_irq, data_avail, midi_tx_valid};
               RDATA_OFS: rdata <= {24'h0, read_byte};
               CONFIG_OFS: rdata <= {20'h0, adc_gain, 6'h0, stereo, 1'b0};
               TIMER_OFS: rdata <= {15'h0, timer_alt, filter_x, timer_x};
               DAC_OFS: rdata <= {15'h0, dac_wide, dac_data};
               BLOCK_OFS: rdata <= {16'h0, block_size};
               default: begin
                  rdata <= 32'h0000_0000;
                  rresp <= RESP_DECERR;
               end
            endcase
         end
         if (rvalid && rready) begin
            rvalid <= 1'b0;
            arready <= 1'b1;
         end
      end
   end

   // ----------------------------------------
   // configuration register
   // ----------------------------------------
   // soft reset is a one-cycle pulse; stereo flag and gain survive it
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         soft_rst <= 1'b0;
         stereo <= 1'b0;
         adc_gain <= GAIN_RESET;
      end else begin
         soft_rst <= 1'b0;
         if (wr_fire && aw_addr == CONFIG_OFS) begin
            if (w_strb[0]) begin
               soft_rst <= w_data[CFG_SRST];
               stereo <= w_data[CFG_STEREO];
            end
            if (w_strb[1])
               adc_gain <= w_data[CFG_GAIN_LSB +: 4];
         end
      end
   end

   // ----------------------------------------
   // command decoding
   // ----------------------------------------
   logic dec_byte;
   logic exec;
   logic [7:0] exec_op;
   logic [7:0] arg_lo;
   logic [7:0] arg_hi;

   // a command-port byte reaches the decoder only outside the MIDI modes
   always_comb begin
      dec_byte = cmd_write && midi_mode == MIDI_OFF;
      exec = 1'b0;
      exec_op = opcode;
      arg_lo = w_data[7:0];
      arg_hi = 8'h00;
      case (dec_state)
         DEC_IDLE: begin
            exec_op = w_data[7:0];
            exec = dec_byte && param_count(w_data[7:0]) == 2'h0;
         end
         DEC_PARAM1: exec = dec_byte && param_count(opcode) == 2'h1;
         DEC_PARAM2: begin
            arg_lo = param_lo; // low byte came first
            arg_hi = w_data[7:0];
            exec = dec_byte;
         end
         default: exec = 1'b0;
      endcase
   end

   // byte gathering: opcode, then as many parameters as it needs
   always_ff @(posedge aclk) begin
      if (!aresetn || soft_rst) begin
         dec_state <= DEC_IDLE;
         opcode <= 8'h00;
         param_lo <= 8'h00;
      end else if (dec_byte) begin
         case (dec_state)
            DEC_IDLE: begin
               opcode <= w_data[7:0];
               if (param_count(w_data[7:0]) != 2'h0)
                  dec_state <= DEC_PARAM1;
            end
            DEC_PARAM1: begin
               param_lo <= w_data[7:0];
               dec_state <= (param_count(opcode) == 2'h2) ? DEC_PARAM2 : DEC_IDLE;
            end
            default: dec_state <= DEC_IDLE;
         endcase
      end
   end

   // ----------------------------------------
   // command effects
   // ----------------------------------------
   logic [15:0] arg_word;
   logic play_ok;
   logic rec_ok;
   assign arg_word = {arg_hi, arg_lo};
   // 16-bit playback and normal recording share the lower ceiling
   assign play_ok = rate_ok(timer_x, timer_alt, exec_op[0] ? RATE_LO_KHZ : RATE_HI_KHZ);
   assign rec_ok = rate_ok(timer_x, timer_alt, exec_op[7] ? RATE_HI_KHZ : RATE_LO_KHZ);

   // a start that would exceed the ceiling is refused and flags rate_err
   always_ff @(posedge aclk) begin
      if (!aresetn || soft_rst) begin
         dac_data <= 16'h8000;
         dac_wide <= 1'b0;
         dac_strobe <= 1'b0;
         dma_start <= 1'b0;
         dma_record <= 1'b0;
         dma_wide <= 1'b0;
         dma_auto <= 1'b0;
         dma_stereo <= 1'b0;
         dma_high_speed <= 1'b0;
         dma_count <= 16'h0000;
         agc_enable <= 1'b1;
         rate_err <= 1'b0;
         block_size <= 16'h0000;
         timer_x <= TIMER_X_RESET;
         filter_x <= TIMER_X_RESET;
         timer_alt <= 1'b0;
      end else begin
         dac_strobe <= 1'b0;
         dma_start <= 1'b0;
         // clear first so a refusal in the same cycle still sets the flag
         if (wr_fire && aw_addr == STATUS_OFS && w_strb[0] && w_data[STAT_RATE_ERR])
            rate_err <= 1'b0;
         if (exec) begin
            case (exec_op)
               OP_DAC8: begin
                  dac_data <= {arg_lo, 8'h00};
                  dac_wide <= 1'b0;
                  dac_strobe <= 1'b1;
               end
               OP_DAC16: begin
                  dac_data <= arg_word;
                  dac_wide <= 1'b1;
                  dac_strobe <= 1'b1;
               end
               OP_PLAY8, OP_PLAY16, OP_PLAY8_AUTO, OP_PLAY16_AUTO: begin
                  if (play_ok) begin
                     dma_start <= 1'b1;
                     dma_record <= 1'b0;
                     dma_wide <= exec_op[0];
                     dma_auto <= exec_op[3];
                     dma_stereo <= stereo;
                     dma_high_speed <= 1'b0;
                     dma_count <= exec_op[3] ? block_size : arg_word;
                  end else begin
                     rate_err <= 1'b1;
                  end
               end
               OP_REC8, OP_REC16, OP_REC8_AUTO, OP_REC16_AUTO,
               OP_HS_REC_AUTO, OP_HS_REC: begin
                  if (rec_ok) begin
                     dma_start <= 1'b1;
                     dma_record <= 1'b1;
                     dma_wide <= exec_op[0] && !exec_op[7];
                     dma_auto <= (exec_op[3] && !exec_op[7])
                                 || exec_op == OP_HS_REC_AUTO;
                     dma_stereo <= 1'b0;
                     dma_high_speed <= exec_op[7];
                     dma_count <= (exec_op[3] || exec_op[7]) ? block_size : arg_word;
                     agc_enable <= !exec_op[0] && !exec_op[7];
                  end else begin
                     rate_err <= 1'b1;
                  end
               end
               OP_ADC8: agc_enable <= 1'b1;
               OP_ADC16: agc_enable <= 1'b0;
               OP_TIMER, OP_TIMER_ALT: begin
                  timer_x <= arg_lo;
                  timer_alt <= exec_op[0];
                  filter_x <= arg_lo;
               end
               OP_FILTER: filter_x <= arg_lo;
               OP_BLOCK: block_size <= arg_word;
               default: ;
            endcase
         end
      end
   end

   // ----------------------------------------
   // read data, MIDI modes and MIDI output
   // ----------------------------------------
   // a received byte is set after the read clears, so it is never lost
   always_ff @(posedge aclk) begin
      if (!aresetn || soft_rst) begin
         midi_mode <= MIDI_OFF;
         irq_en <= 1'b0;
         midi_irq <= 1'b0;
         read_byte <= 8'h00;
         hi_byte <= 8'h00;
         hi_pending <= 1'b0;
         data_avail <= 1'b0;
         midi_tx_valid <= 1'b0;
         midi_tx_data <= 8'h00;
      end else begin
         if (midi_tx_valid && midi_tx_ready)
            midi_tx_valid <= 1'b0;
         if (rdata_read) begin
            midi_irq <= 1'b0;
            if (hi_pending) begin
               read_byte <= hi_byte; // high byte follows the low one
               hi_pending <= 1'b0;
            end else begin
               data_avail <= 1'b0;
            end
         end
         if (cmd_write && midi_mode == MIDI_INPUT)
            midi_mode <= MIDI_OFF; // written value dropped
         if (cmd_write && midi_mode == MIDI_UART && !midi_tx_valid) begin
            midi_tx_data <= w_data[7:0];
            midi_tx_valid <= 1'b1;
         end
         if (exec) begin
            case (exec_op)
               OP_ADC8: begin
                  read_byte <= adc_sample[15:8];
                  data_avail <= 1'b1;
               end
               OP_ADC16: begin
                  read_byte <= adc_sample[7:0];
                  hi_byte <= adc_sample[15:8];
                  hi_pending <= 1'b1;
                  data_avail <= 1'b1;
               end
               OP_MIDI_IN, OP_MIDI_IN_IRQ: begin
                  midi_mode <= MIDI_INPUT;
                  irq_en <= exec_op[0];
               end
               OP_MIDI_UART, OP_MIDI_UART_IRQ: begin
                  midi_mode <= MIDI_UART;
                  irq_en <= exec_op[0];
               end
               OP_MIDI_OUT: if (!midi_tx_valid) begin
                  midi_tx_data <= arg_lo;
                  midi_tx_valid <= 1'b1;
               end
               default: ;
            endcase
         end
         if (midi_rx_valid && midi_mode != MIDI_OFF) begin
            read_byte <= midi_rx_data;
            hi_pending <= 1'b0;
            data_avail <= 1'b1;
            if (irq_en)
               midi_irq <= 1'b1;
         end
      end
   end

   // ----------------------------------------
   // sample timer and filter clock
   // ----------------------------------------
   // a phase accumulator makes the 1, 1.5 and 7.16 MHz bases from aclk,
   // so ticks jitter by one aclk but hold the right mean rate
   logic [1:0] tick;
   genvar gi;
   generate
      for (gi = 0; gi < 2; gi++) begin : gen_rate
         logic [25:0] acc;
         logic [8:0] cnt;
         logic [25:0] base;
         logic [25:0] sum;
         logic [8:0] div;
         assign base = (gi == 1) ? 26'(FILTER_HZ) : (timer_alt ? 26'(TIMER_ALT_HZ)
                                                               : 26'(TIMER_HZ));
         assign sum = acc + base;
         assign div = 9'h100 - {1'b0, (gi == 1) ? filter_x : timer_x};
         always_ff @(posedge aclk) begin
            if (!aresetn) begin
               acc <= 26'h0;
               cnt <= 9'h0;
               tick[gi] <= 1'b0;
            end else begin
               tick[gi] <= 1'b0;
               if (sum >= 26'(CLK_HZ)) begin
                  acc <= sum - 26'(CLK_HZ);
                  if (cnt >= div - 9'h1) begin
                     cnt <= 9'h0;
                     tick[gi] <= 1'b1; // base/(256-X)
                  end else begin
                     cnt <= cnt + 9'h1;
                  end
               end else begin
                  acc <= sum;
               end
            end
         end
      end
   endgenerate

   // filter tick drives the switched-capacitor filter, corner near 1/82 of it
   assign sample_tick = tick[0];
   assign filter_tick = tick[1];
endmodule
`default_nettype wire

// File: tb/dsp_cmd_checker_assertions.sv
/* port checker for the command decoder, bound after the module.
   assumes one clock domain and the low synchronous reset. */
`timescale 1ns/10ps
`default_nettype none
module dsp_cmd_checker (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic bvalid,
   input wire logic [15:0] dac_data,
   input wire logic dac_wide,
   input wire logic dac_strobe,
   input wire logic agc_enable,
   input wire logic dma_start,
   input wire logic dma_record,
   input wire logic dma_wide,
   input wire logic dma_high_speed,
   input wire logic midi_tx_valid,
   input wire logic midi_tx_ready,
   input wire logic [7:0] midi_tx_data,
   input wire logic midi_rx_valid,
   input wire logic midi_irq
);
   default clocking @(posedge aclk); endclocking
   default disable iff (!aresetn);
   // effects land with the write response, never before the last byte
   dac_resp_a: assert property (dac_strobe |-> $rose(bvalid))
      else $error("dac late");
   dac_pad_a: assert property (dac_strobe && !dac_wide |-> dac_data[7:0] == 8'h00)
      else $error("dac pad");
   dma_resp_a: assert property (dma_start |-> $rose(bvalid))
      else $error("dma late");
   dma_pulse_a: assert property (dma_start |=> !dma_start)
      else $error("dma long");
   agc_on_a: assert property (
      dma_start && dma_record && !(dma_wide || dma_high_speed) |-> agc_enable) else $error("agc");
   hs_agc_a: assert property (dma_start && dma_high_speed |-> !agc_enable)
      else $error("hs agc");
   tx_hold_a: assert property (
      midi_tx_valid && !midi_tx_ready |=> midi_tx_valid && $stable(midi_tx_data)) else $error("tx");
   irq_src_a: assert property ($rose(midi_irq) |-> $past(midi_rx_valid))
      else $error("irq");
endmodule
bind dsp_cmd_decoder dsp_cmd_checker dsp_cmd_checker_inst (.*);
`default_nettype wire

// File: tb/midi_far.sv
/* far-side midi model: takes serial bytes with random stalls and
   sends received bytes when the bench asks. */
`timescale 1ns/10ps
`default_nettype none
module midi_far (
   input wire logic aclk,
   input wire logic midi_tx_valid,
   input wire logic [7:0] midi_tx_data,
   output logic midi_tx_ready,
   output logic midi_rx_valid,
   output logic [7:0] midi_rx_data,
   output logic [7:0] tx_last
);
   initial {midi_tx_ready, midi_rx_valid, midi_rx_data, tx_last} = '0;
   // a byte counts only at an edge with valid and ready high
   always @(posedge aclk) begin
      midi_tx_ready <= 1'($urandom);
      if (midi_tx_valid && midi_tx_ready) tx_last <= midi_tx_data;
   end
   // idle line shows the inverse so no stale byte looks new
   task automatic send_rx(input logic [7:0] v);
      {midi_rx_valid, midi_rx_data} <= {1'b1, v};
      @(posedge aclk);
      {midi_rx_valid, midi_rx_data} <= {1'b0, ~v};
   endtask
endmodule
`default_nettype wire

// File: tb/tb.sv
/* self-checking bench for the command decoder over axi-lite.
   assumes the midi model and the bound checker are compiled first. */
`timescale 1ns/10ps
`default_nettype none
module tb;
   import dsp_cmd_pkg::*;
   logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready;
   logic rvalid, rready, dac_wide, dac_strobe, agc_enable, dma_start, dma_record, dma_wide;
   logic dma_auto, dma_stereo, dma_high_speed, sample_tick, filter_tick, midi_rx_valid;
   logic midi_tx_valid, midi_tx_ready, midi_irq, hs, rec, wide, au, ok, st;
   logic [1:0] bresp, rresp, r;
   logic [3:0] wstrb, adc_gain;
   logic [7:0] awaddr, araddr, midi_rx_data, midi_tx_data, tx_last, c0, starts = 0;
   logic [15:0] dac_data, adc_sample, dma_count, b, blk, p;
   logic [31:0] wdata, rdata, d;
   logic [20:0] cap;
   logic [7:0] ops [10] = '{8'h14, 8'h15, 8'h1c, 8'h1d, 8'h24, 8'h25, 8'h2c, 8'h2d, 8'h98, 8'h99};
   int err_total = 0, checked = 0, i, gap = 0, span = 0;
   dsp_cmd_decoder dsp_cmd_decoder_inst (.*);
   midi_far midi_far_inst (.*);
   initial begin
      aclk = 1'b0;
      forever #20 aclk = ~aclk;
   end
   // reference side: count start pulses and keep what came with them
   always @(posedge aclk) begin
      if (dma_start === 1'b1) begin
         starts <= starts + 8'h01;
         cap <= {dma_stereo, dma_record, dma_wide, dma_auto, dma_high_speed, dma_count};
      end
   end
   // spacing of sample ticks, for the timer rate check
   always @(posedge aclk) begin
      gap <= (sample_tick === 1'b1) ? 1 : gap + 1;
      if (sample_tick === 1'b1) span <= gap;
   end
   task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
      checked++;
      if (g !== e) begin
         err_total++;
         $display("CHECK FAILED %s expected %h seen %h", s, e, g);
      end
   endtask
   task automatic close_out();
      $display("checks %0d mismatches %0d", checked, err_total);
      if (err_total == 0 && checked > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask
   // one bus cycle; a response that never comes ends the run
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] v);
      if (w) {awaddr, wdata, awvalid, wvalid, bready} <= {a, v, 3'b111};
      else {araddr, arvalid, rready} <= {a, 2'b11};
      for (int n = 0; n < 60; n++) begin
         @(posedge aclk);
         if (w && awready === 1'b1) awvalid <= 1'b0;
         if (w && wready === 1'b1) wvalid <= 1'b0;
         if (!w && arready === 1'b1) arvalid <= 1'b0;
         if ((w ? bvalid : rvalid) === 1'b1) break;
      end
      {d, r} = {rdata, w ? bresp : rresp};
      if ((w ? bvalid : rvalid) !== 1'b1) begin
         err_total++;
         close_out();
      end
   endtask
   task automatic cmd(input logic [7:0] o, input int n, input logic [15:0] v);
      bus(1'b1, CMD_OFS, 32'(o));
      for (int i = 0; i < n; i++) bus(1'b1, CMD_OFS, 32'(v[8*i+:8]));
   endtask
   initial begin
      {aresetn, awvalid, wvalid, bready, arvalid, rready, awaddr, araddr, wdata} = '0;
      {wstrb, adc_sample} = {4'hf, 16'h5ac3};
      c0 = 8'($urandom(32'h572cc1c2));
      repeat (2) @(posedge aclk);
      aresetn <= 1'b1;
      b = 16'($urandom);
      cmd(OP_DAC8, 1, b);
      chk("dac8", 32'({b[7:0], 8'h00}), 32'(dac_data));
      cmd(OP_DAC16, 2, b);
      chk("dac16", 32'({1'b1, b}), 32'({dac_wide, dac_data}));
      cmd(OP_ADC16, 0, b);
      bus(1'b0, RDATA_OFS, 32'h0);
      chk("adc lo", 32'h0c3, 32'(d[7:0]));
      bus(1'b0, RDATA_OFS, 32'h0);
      chk("adc hi", 32'h05a, 32'(d[7:0]));
      cmd(OP_ADC8, 0, b);
      bus(1'b0, RDATA_OFS, 32'h0);
      chk("adc8", 32'h05a, 32'(d[7:0]));
      $display("test direct done");
      cmd(OP_TIMER, 1, 16'd233);
      repeat (1300) @(posedge aclk);
      chk("tick gap", CLK_HZ / TIMER_HZ * 23, 32'(span));
      cmd(OP_FILTER, 1, b);
      bus(1'b0, TIMER_OFS, 32'h0);
      chk("timer reg", 32'({b[7:0], 8'd233}), 32'(d[16:0]));
      blk = 16'($urandom);
      cmd(OP_BLOCK, 2, blk);
      // second pass runs at a slow rate, so every start is allowed
      for (int j = 0; j < 20; j++) begin
         i = j % 10;
         if (j == 10) cmd(OP_TIMER_ALT, 1, 16'd180);
         {st, p} = 17'($urandom);
         bus(1'b1, CONFIG_OFS, 32'({4'h8, 6'h0, st, 1'b0}));
         {hs, rec, wide} = {ops[i][7], ops[i][5] | ops[i][7], ops[i][0] & ~ops[i][7]};
         au = hs ? ~ops[i][0] : ops[i][3];
         ok = (j > 9) | (~wide & (~rec | hs));
         c0 = starts;
         cmd(ops[i], (au | hs) ? 0 : 2, p);
         @(posedge aclk);
         chk("start", 32'(ok), 32'(starts - c0));
         if (ok) chk("dma", 32'({~rec & st, rec, wide, au, hs, (au | hs) ? blk : p}),
            32'({~rec & cap[20], cap[19:0]}));
         bus(1'b0, STATUS_OFS, 32'h0);
         chk("rate err", 32'(!ok), 32'(d[STAT_RATE_ERR]));
         bus(1'b1, STATUS_OFS, 32'h8);
      end
      $display("test dma done");
      cmd(OP_MIDI_OUT, 1, b);
      for (int n = 0; n < 40 && tx_last !== b[7:0]; n++) @(posedge aclk);
      chk("midi out", 32'(b[7:0]), 32'(tx_last));
      cmd(OP_MIDI_IN_IRQ, 0, b);
      midi_far_inst.send_rx(b[15:8]);
      bus(1'b0, STATUS_OFS, 32'h0);
      chk("midi stat", 32'h0b, 32'(d[5:1]));
      bus(1'b0, RDATA_OFS, 32'h0);
      chk("midi byte", 32'(b[15:8]), 32'(d[7:0]));
      bus(1'b1, CMD_OFS, 32'(OP_DAC8));
      bus(1'b0, STATUS_OFS, 32'h0);
      chk("midi exit", 32'h20, 32'(d[6:1]));
      cmd(OP_MIDI_UART, 0, b);
      c0 = ~b[7:0];
      bus(1'b1, CMD_OFS, 32'(c0));
      for (int n = 0; n < 40 && tx_last !== c0; n++) @(posedge aclk);
      chk("uart out", 32'(c0), 32'(tx_last));
      bus(1'b1, CONFIG_OFS, 32'h801);
      bus(1'b0, STATUS_OFS, 32'h0);
      chk("soft reset", 32'h20, 32'(d[6:1]));
      bus(1'b0, 8'h40, 32'h0);
      chk("unmapped", 32'(RESP_DECERR), 32'(r));
      bus(1'b1, 8'h40, 32'h0);
      chk("unmapped w", 32'(RESP_DECERR), 32'(r));
      $display("test midi done");
      close_out();
   end
endmodule
`default_nettype wire
